// >>> cbcd_pkg.sv
// Summary of operation
// [R1] every cycle command takes effect within one machine cycle
// [R2] unassigned command codes leave ports, timer and control port unchanged; code still latches the bus address and ends a pending service
// [R3] reset command clears port A, port B, timer and control port
// [R4] low-vector command drives low vector byte if requesting and chain input low
// [R5] inhibit command freezes requests from altering the chain output
// [R6] high-vector command drives high vector byte and resets interrupt circuit
// [R7] port write loads bus into port selected by previous cycle address
// [R8] port read drives port A or B selected by previous cycle address
// [R9] short cycle after high vector clears the serviced request latch
// [R10] that same short cycle lifts the chain freeze
// [R11] host clears its interrupt enable bit after the vector transfer
// [R12] shortest response is 27 phase periods plus input setup
// [R13] free-running timer reloads with no lost or added ticks
// [R14] every bus value is compared to four addresses, match held a cycle
// [R15] vector bit 7 is 0 for timer, 1 for external request
// [R16] timer request is serviced before external request
// [R17] chain output high when request pending or chain input high
// [R18] data bus driven only for port data or vector bytes
package cbcd_pkg;
    // cycle command codes
    localparam logic [4:0] CMD_RESET   = 5'h08;
    localparam logic [4:0] CMD_VEC_LO  = 5'h0F;
    localparam logic [4:0] CMD_INHIBIT = 5'h10;
    localparam logic [4:0] CMD_VEC_HI  = 5'h13;
    localparam logic [4:0] CMD_PWRITE  = 5'h1A;
    localparam logic [4:0] CMD_PREAD   = 5'h1B;
    // port selection within the four addresses
    localparam logic [1:0] SEL_PORT_A  = 2'h0;
    localparam logic [1:0] SEL_PORT_B  = 2'h1;
    localparam logic [1:0] SEL_TIMER   = 2'h2;
    localparam logic [1:0] SEL_CTRL    = 2'h3;
    // control port fields
    localparam int CTRL_EXT_EN   = 0;
    localparam int CTRL_TMR_EN   = 1;
    localparam int CTRL_TMR_RUN  = 3;
    // vector bit that names the source
    localparam int VEC_SRC_BIT   = 7;
    // reset values
    localparam logic [7:0] PORT_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'h00;
    // response time in phase periods
    localparam int RESP_PHASE_PERIODS = 27;
endpackage

// >>> cbcd_decoder.sv
`timescale 1ns/10ps
module cbcd_decoder #(
    parameter logic [7:0] BASE_ADDR = 8'h04,
    parameter logic [7:0] VEC_HI    = 8'h02,
    parameter logic [7:0] VEC_LO    = 8'h00,
    parameter int         PRESCALE  = 2
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // host cycle interface
    input  wire logic [4:0] cpu_cycle_command,
    input  wire logic       cycle_end,
    input  wire logic       phase_tick,
    // shared data bus
    input  wire logic [7:0] data_bus_in,
    output logic      [7:0] data_bus_out,
    output logic            data_bus_oe_n,
    // priority chain and request
    input  wire logic       priority_chain_in,
    output logic            priority_chain_out,
    output logic            int_request,
    input  wire logic       external_interrupt_input,
    // i/o ports
    output logic      [7:0] port_a,
    output logic      [7:0] port_b
);
    import cbcd_pkg::*;

    logic [7:0] port_a_r, port_b_r, ctrl_r, timer_r, reload_r;
    logic [7:0] dout_r, dout_nxt;
    logic       oe_n_r, oe_n_nxt;
    logic       hit_r;
    logic [1:0] hit_sel_r;
    logic       tmr_req_r, ext_req_r, ext_d_r;
    logic       frozen_r, snap_tmr_r, snap_ext_r;
    logic       svc_pend_r, svc_tmr_r;
    logic       chain_out_r, int_req_r;
    logic [7:0] psc_r;
    logic       tmr_tick, tmr_expire, ext_rise;
    logic       eff_tmr, eff_ext, eff_any, respond;

    // address window decode on bits 7:2, used for match only; selection takes bits 1:0
    function automatic logic addr_match(input logic [7:0] v);
        return v[7:2] == BASE_ADDR[7:2];
    endfunction

    // requests seen by the chain, frozen copy while inhibited
    assign eff_tmr = frozen_r ? snap_tmr_r : tmr_req_r; // [R5]
    assign eff_ext = frozen_r ? snap_ext_r : ext_req_r;
    assign eff_any = eff_tmr | eff_ext;
    assign respond = eff_any & ~priority_chain_in; // [R4]

    // address match held through the following cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hit_r     <= 1'b0;
            hit_sel_r <= 2'h0;
        end else if (cycle_end) begin
            hit_r     <= addr_match(data_bus_in); // [R14]
            hit_sel_r <= data_bus_in[1:0];
        end
    end

    // i/o ports and control port
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port_a_r <= PORT_RST;
            port_b_r <= PORT_RST;
            ctrl_r   <= CTRL_RST;
        end else if (cycle_end) begin
            unique case (cpu_cycle_command)
                CMD_RESET: begin
                    port_a_r <= PORT_RST; // [R3]
                    port_b_r <= PORT_RST;
                    ctrl_r   <= CTRL_RST;
                end
                CMD_PWRITE: begin
                    if (hit_r) begin
                        unique case (hit_sel_r) // [R7]
                            SEL_PORT_A: port_a_r <= data_bus_in;
                            SEL_PORT_B: port_b_r <= data_bus_in;
                            SEL_CTRL:   ctrl_r   <= data_bus_in;
                            SEL_TIMER: begin
                            end
                        endcase
                    end
                end
                default: begin
                    // other codes leave the ports alone
                end
            endcase
        end
    end

    // prescaler producing timer ticks from phase ticks
    assign tmr_tick = phase_tick & ctrl_r[CTRL_TMR_RUN]
                    & (psc_r == 8'(PRESCALE - 1));
    assign tmr_expire = tmr_tick & (timer_r == 8'h01);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            psc_r <= 8'h00;
        end else if (phase_tick & ctrl_r[CTRL_TMR_RUN]) begin
            psc_r <= tmr_tick ? 8'h00 : psc_r + 8'h01;
        end
    end

    // timer counter, reload on the same tick that expires
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timer_r  <= TIMER_RST;
            reload_r <= TIMER_RST;
        end else if (cycle_end && cpu_cycle_command == CMD_RESET) begin
            timer_r  <= TIMER_RST; // [R3]
            reload_r <= TIMER_RST;
        end else if (cycle_end && cpu_cycle_command == CMD_PWRITE
                     && hit_r && hit_sel_r == SEL_TIMER) begin
            timer_r  <= data_bus_in; // [R7]
            reload_r <= data_bus_in;
        end else if (tmr_expire) begin
            timer_r <= reload_r; // [R13]
        end else if (tmr_tick) begin
            timer_r <= timer_r - 8'h01;
        end
    end

    // external edge detect
    assign ext_rise = external_interrupt_input & ~ext_d_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= external_interrupt_input;
        end
    end

    // request latches, a new event wins over the clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tmr_req_r <= 1'b0;
            ext_req_r <= 1'b0;
        end else begin
            if (tmr_expire && ctrl_r[CTRL_TMR_EN]) begin
                tmr_req_r <= 1'b1;
            end else if (cycle_end && svc_pend_r && svc_tmr_r) begin
                tmr_req_r <= 1'b0; // [R9]
            end
            if (ext_rise && ctrl_r[CTRL_EXT_EN]) begin
                ext_req_r <= 1'b1;
            end else if (cycle_end && svc_pend_r && !svc_tmr_r) begin
                ext_req_r <= 1'b0; // [R9]
            end
        end
    end

    // chain freeze and service tracking
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            frozen_r   <= 1'b0;
            snap_tmr_r <= 1'b0;
            snap_ext_r <= 1'b0;
            svc_pend_r <= 1'b0;
            svc_tmr_r  <= 1'b0;
        end else if (cycle_end) begin
            if (svc_pend_r) begin
                frozen_r   <= 1'b0; // [R10]
                svc_pend_r <= 1'b0;
            end else if (cpu_cycle_command == CMD_INHIBIT) begin
                frozen_r   <= 1'b1; // [R5]
                snap_tmr_r <= tmr_req_r;
                snap_ext_r <= ext_req_r;
            end else if (cpu_cycle_command == CMD_VEC_HI && respond) begin
                svc_pend_r <= 1'b1; // [R6]
                svc_tmr_r  <= eff_tmr; // [R16]
            end
        end
    end

    // chain output and request to the host
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            chain_out_r <= 1'b0;
            int_req_r   <= 1'b0;
        end else begin
            chain_out_r <= priority_chain_in | eff_any; // [R17]
            int_req_r   <= respond & ~svc_pend_r; // [R12]
        end
    end

    // bus drive decision for the current command
    always_comb begin
        dout_nxt = 8'h00;
        oe_n_nxt = 1'b1; // [R18]
        if (!cycle_end) begin
            unique case (cpu_cycle_command)
                CMD_VEC_LO: begin
                    if (respond && !svc_pend_r) begin
                        dout_nxt = VEC_LO; // [R4]
                        dout_nxt[VEC_SRC_BIT] = ~eff_tmr; // [R15]
                        oe_n_nxt = 1'b0;
                    end
                end
                CMD_VEC_HI: begin
                    if (respond && !svc_pend_r) begin
                        dout_nxt = VEC_HI; // [R6]
                        oe_n_nxt = 1'b0;
                    end
                end
                CMD_PREAD: begin
                    if (hit_r && hit_sel_r == SEL_PORT_A) begin
                        dout_nxt = port_a_r; // [R8]
                        oe_n_nxt = 1'b0;
                    end else if (hit_r && hit_sel_r == SEL_PORT_B) begin
                        dout_nxt = port_b_r; // [R8]
                        oe_n_nxt = 1'b0;
                    end
                end
                default: begin
                    // no drive; unassigned codes are no-ops [R2]
                end
            endcase
        end
    end

    // bus drive registers, released at each cycle end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dout_r <= 8'h00;
            oe_n_r <= 1'b1;
        end else begin
            dout_r <= dout_nxt; // [R1]
            oe_n_r <= oe_n_nxt;
        end
    end

    assign data_bus_out       = dout_r;
    assign data_bus_oe_n      = oe_n_r;
    assign priority_chain_out = chain_out_r;
    assign int_request        = int_req_r;
    assign port_a             = port_a_r;
    assign port_b             = port_b_r;

    // checks
    sequence s_vec_hi_taken;
        cycle_end && cpu_cycle_command == CMD_VEC_HI && respond
            && !svc_pend_r;
    endsequence

    sequence s_service_close;
        cycle_end && svc_pend_r;
    endsequence

    AST_RESET_CLEARS: assert property ( // [R3]
        @(posedge clock) disable iff (!arst_n)
        cycle_end && cpu_cycle_command == CMD_RESET
        |=> port_a_r == 8'h00 && port_b_r == 8'h00 && ctrl_r == 8'h00
            && timer_r == 8'h00)
        else $error("reset command did not clear registers");

    AST_NOOP_QUIET: assert property ( // [R2]
        @(posedge clock) disable iff (!arst_n)
        cycle_end && cpu_cycle_command == 5'h00
        |=> $stable(port_a_r) && $stable(port_b_r) && $stable(ctrl_r))
        else $error("unassigned command changed state");

    AST_VEC_LO_DRIVE: assert property ( // [R4]
        @(posedge clock) disable iff (!arst_n)
        !cycle_end && cpu_cycle_command == CMD_VEC_LO && respond
            && !svc_pend_r
        |=> !oe_n_r && dout_r[VEC_SRC_BIT] == !$past(eff_tmr))
        else $error("low vector byte not driven");

    AST_FREEZE_HOLDS: assert property ( // [R5]
        @(posedge clock) disable iff (!arst_n)
        frozen_r && $stable(frozen_r) && !priority_chain_in
            && $stable(priority_chain_in)
        |=> $stable(chain_out_r))
        else $error("chain output moved while frozen");

    AST_PWRITE_A: assert property ( // [R7]
        @(posedge clock) disable iff (!arst_n)
        cycle_end && cpu_cycle_command == CMD_PWRITE && hit_r
            && hit_sel_r == SEL_PORT_A
        |=> port_a_r == $past(data_bus_in))
        else $error("port write did not load port A");

    AST_PREAD_B: assert property ( // [R8]
        @(posedge clock) disable iff (!arst_n)
        !cycle_end && cpu_cycle_command == CMD_PREAD && hit_r
            && hit_sel_r == SEL_PORT_B
        |=> !oe_n_r && dout_r == $past(port_b_r))
        else $error("port read did not drive port B");

    AST_SERVICE_OPEN: assert property ( // [R6]
        @(posedge clock) disable iff (!arst_n)
        s_vec_hi_taken |=> svc_pend_r)
        else $error("vector transfer did not start service");

    AST_SERVICE_END: assert property ( // [R10]
        @(posedge clock) disable iff (!arst_n)
        s_service_close |=> !frozen_r && !svc_pend_r)
        else $error("freeze not lifted after vector transfer");

    AST_CHAIN_OUT: assert property ( // [R17]
        @(posedge clock) disable iff (!arst_n)
        priority_chain_in |=> chain_out_r)
        else $error("chain input not passed on");

    AST_REQ_PROMPT: assert property ( // [R12]
        @(posedge clock) disable iff (!arst_n)
        $rose(tmr_req_r) && !frozen_r && !svc_pend_r && !priority_chain_in
        |=> int_req_r)
        else $error("request not passed to host at once");

    AST_BUS_FLOAT: assert property ( // [R18]
        @(posedge clock) disable iff (!arst_n)
        cycle_end |=> oe_n_r)
        else $error("bus still driven after cycle end");

    AST_TIMER_RELOAD: assert property ( // [R13]
        @(posedge clock) disable iff (!arst_n)
        tmr_expire && !cycle_end |=> timer_r == $past(reload_r))
        else $error("timer reload lost");
endmodule

// >>> cbcd_host_model.sv
`timescale 1ns/10ps
module cbcd_host_model (
    // clock
    input  wire logic       clock,
    // cycle command lines
    output logic      [4:0] cpu_cycle_command,
    output logic            cycle_end,
    // shared data bus
    input  wire logic [7:0] data_bus_out,
    input  wire logic       data_bus_oe_n,
    output logic      [7:0] data_bus_in
);
    import cbcd_pkg::*;
    logic [7:0] host_val_r;
    logic       host_en_r;
    logic [7:0] last_r;
    logic       cpu_interrupt_enable_bit;

    // idle values before the first machine cycle
    initial begin
        cpu_cycle_command = 5'h00;
        cycle_end = 1'b0;
        host_val_r = 8'h00;
        host_en_r = 1'b0;
        last_r = 8'h00;
        cpu_interrupt_enable_bit = 1'b1;
    end

    // wire level; a released bus shows the inverse of its last value
    always_comb begin
        if (!data_bus_oe_n)
            data_bus_in = data_bus_out;
        else if (host_en_r)
            data_bus_in = host_val_r;
        else
            data_bus_in = ~last_r;
    end

    // remember the last level so a floating bus keeps moving
    always @(posedge clock) begin
        last_r <= data_bus_in;
    end

    // one short machine cycle: three clocks, then the write edge
    task automatic run_cycle(input logic [4:0] cmd, input logic [7:0] val,
                             input logic drv);
        cpu_cycle_command <= cmd;
        host_val_r <= val;
        host_en_r <= drv;
        repeat (3) @(posedge clock);
        cycle_end <= 1'b1;
        @(posedge clock);
        cycle_end <= 1'b0;
        if (cmd == CMD_VEC_HI)
            cpu_interrupt_enable_bit <= 1'b0;
    endtask
endmodule

// >>> test_cpu_bus_command_decoder.sv
`timescale 1ns/10ps
module test_cpu_bus_command_decoder;
    import cbcd_pkg::*;
    localparam logic [7:0] BASE = 8'h04;
    localparam logic [7:0] VLO  = 8'h00;
    localparam logic [7:0] VHI  = 8'h02;
    // design-facing signals
    logic       clock;
    logic       arst_n;
    logic [4:0] cpu_cycle_command;
    logic       cycle_end;
    logic       phase_tick;
    logic [7:0] data_bus_in;
    logic [7:0] data_bus_out;
    logic       data_bus_oe_n;
    logic       priority_chain_in;
    logic       priority_chain_out;
    logic       int_request;
    logic       external_interrupt_input;
    logic [7:0] port_a;
    logic [7:0] port_b;
    // bench state
    logic [8:0]  exp_q[$];
    logic [31:0] seed_r;
    logic [7:0]  val_a;
    logic [7:0]  val_b;
    int          bad_count;
    int          total_checks;
    int          cycles;

    cbcd_decoder #(.PRESCALE(1)) dut (
        .clock(clock), .arst_n(arst_n),
        .cpu_cycle_command(cpu_cycle_command), .cycle_end(cycle_end),
        .phase_tick(phase_tick), .data_bus_in(data_bus_in),
        .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n),
        .priority_chain_in(priority_chain_in),
        .priority_chain_out(priority_chain_out), .int_request(int_request),
        .external_interrupt_input(external_interrupt_input),
        .port_a(port_a), .port_b(port_b));

    cbcd_host_model host (
        .clock(clock), .cpu_cycle_command(cpu_cycle_command),
        .cycle_end(cycle_end), .data_bus_out(data_bus_out),
        .data_bus_oe_n(data_bus_oe_n), .data_bus_in(data_bus_in));

    // clock generator
    always #2 clock = ~clock;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // bus drive seen at each write edge against the oldest note
    always @(posedge clock) begin
        if (cycle_end === 1'b1 && exp_q.size() > 0)
            check({~data_bus_oe_n, data_bus_oe_n ? 8'h00 : data_bus_out},
                  exp_q.pop_front());
    end

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict;
        end
    end

    task automatic cyc(input logic [4:0] cmd, input logic [7:0] val,
                       input logic drv, input logic [8:0] exp);
        exp_q.push_back(exp);
        host.run_cycle(cmd, val, drv);
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] val);
        cyc(5'h00, BASE | {6'h00, sel}, 1'b1, 9'h000);
        cyc(CMD_PWRITE, val, 1'b1, 9'h000);
    endtask

    task automatic rd(input logic [1:0] sel, input logic [8:0] exp);
        cyc(5'h00, BASE | {6'h00, sel}, 1'b1, 9'h000);
        cyc(CMD_PREAD, 8'h00, 1'b0, exp);
    endtask

    task automatic chk_ports(input logic [7:0] a, input logic [7:0] b);
        @(negedge clock);
        check({1'b0, port_a}, {1'b0, a});
        check({1'b0, port_b}, {1'b0, b});
        @(posedge clock);
    endtask

    task automatic chk_irq(input logic r, input logic c);
        // request and chain outputs settle one clock after the latches
        @(posedge clock);
        @(negedge clock);
        check({8'h00, int_request}, {8'h00, r});
        check({8'h00, priority_chain_out}, {8'h00, c});
        @(posedge clock);
    endtask

    // freeze, settle, two vector bytes, then the closing short cycle
    task automatic svc(input logic [7:0] lo);
        cyc(CMD_INHIBIT, 8'h00, 1'b0, 9'h000);
        cyc(5'h00, 8'h00, 1'b0, 9'h000);
        cyc(CMD_VEC_LO, 8'h00, 1'b0, {1'b1, lo});
        cyc(CMD_VEC_HI, 8'h00, 1'b0, {1'b1, VHI});
        cyc(5'h00, 8'h00, 1'b0, 9'h000);
        check({8'h00, host.cpu_interrupt_enable_bit}, 9'h000);
    endtask

    // main sequence
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        phase_tick = 1'b0;
        priority_chain_in = 1'b0;
        external_interrupt_input = 1'b0;
        seed_r = 32'hC0E697AC;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        wr(2'h0, 8'h5A);
        wr(2'h1, 8'hA5);
        cyc(CMD_RESET, 8'h00, 1'b0, 9'h000);
        chk_ports(8'h00, 8'h00);
        $display("test reset done");
        seed_r = lfsr_next(seed_r);
        val_a = seed_r[7:0];
        val_b = seed_r[15:8];
        wr(2'h0, val_a);
        wr(2'h1, val_b);
        chk_ports(val_a, val_b);
        rd(2'h0, {1'b1, val_a});
        rd(2'h1, {1'b1, val_b});
        rd(2'h2, 9'h000);
        rd(2'h3, 9'h000);
        $display("test ports done");
        cyc(5'h00, BASE ^ 8'h08, 1'b1, 9'h000);
        cyc(CMD_PWRITE, ~val_a, 1'b1, 9'h000);
        for (int i = 0; i < 32; i++) begin
            if (!(i inside {8, 15, 16, 19, 26, 27})) begin
                seed_r = lfsr_next(seed_r);
                cyc(5'h00, BASE, 1'b1, 9'h000);
                cyc(i[4:0], seed_r[7:0], 1'b1, 9'h000);
            end
        end
        chk_ports(val_a, val_b);
        $display("test no-op codes done");
        priority_chain_in <= 1'b1;
        cyc(5'h00, 8'h00, 1'b0, 9'h000);
        chk_irq(1'b0, 1'b1);
        cyc(CMD_VEC_LO, 8'h00, 1'b0, 9'h000);
        priority_chain_in <= 1'b0;
        $display("test chain input done");
        wr(2'h2, 8'h01);
        wr(2'h3, 8'h0B);
        phase_tick <= 1'b1;
        external_interrupt_input <= 1'b1;
        @(posedge clock);
        phase_tick <= 1'b0;
        cyc(5'h00, 8'h00, 1'b0, 9'h000);
        chk_irq(1'b1, 1'b1);
        svc(VLO);
        chk_irq(1'b1, 1'b1);
        svc(VLO | 8'h80);
        chk_irq(1'b0, 1'b0);
        external_interrupt_input <= 1'b0;
        $display("test interrupt done");
        print_verdict;
    end
endmodule
